// *** core/cpc_axil_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module cpc_axil_slave (
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic            ce,
	input  wire logic [13:0]     awaddr,
	input  wire logic            awvalid,
	output logic                 awready,
	input  wire logic [31:0]     wdata,
	input  wire logic [3:0]      wstrb,
	input  wire logic            wvalid,
	output logic                 wready,
	output logic [1:0]           bresp,
	output logic                 bvalid,
	input  wire logic            bready,
	input  wire logic [13:0]     araddr,
	input  wire logic            arvalid,
	output logic                 arready,
	output logic [31:0]          rdata,
	output logic [1:0]           rresp,
	output logic                 rvalid,
	input  wire logic            rready,
	output cpc_pkg::cpc_wr_req_t wr,
	input  wire logic            wr_err,
	output cpc_pkg::cpc_rd_req_t rd,
	input  wire cpc_pkg::cpc_rd_rsp_t rd_rsp
);
	import cpc_pkg::*;

	localparam cpc_axil_st_t ST_RST = '0;

	cpc_axil_st_t s;
	cpc_axil_st_t next_s;

	// Ready drops while frozen so no beat is taken and then lost
	assign awready = ce && !s.aw_held && !s.bvalid;
	assign wready  = ce && !s.w_held && !s.bvalid;
	assign arready = ce && !s.rvalid;
	assign bvalid  = s.bvalid;
	assign bresp   = s.bresp;
	assign rvalid  = s.rvalid;
	assign rdata   = s.rdata;
	assign rresp   = s.rresp;

	assign wr = '{en: ce && s.aw_held && s.w_held, addr: s.aw_addr, data: s.w_data,
		strb: s.w_strb};
	assign rd = '{en: arvalid && arready, addr: araddr};

	always_comb begin
		next_s = s;
		if (awvalid && awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_s.w_held = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (wr.en) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = wr_err ? `CPC_RESP_SLVERR : `CPC_RESP_OKAY;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (rd.en) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd_rsp.data;
			next_s.rresp  = rd_rsp.err ? `CPC_RESP_SLVERR : `CPC_RESP_OKAY;
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= ST_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

endmodule
`default_nettype wire

// *** core/cpc_defs.svh ***
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

// Register indices; byte address is four times the index
`define CPC_IDX_LOOP        12'h010
`define CPC_IDX_CAL         12'h018
`define CPC_IDX_PREDIV      12'h1E0
`define CPC_IDX_SRC         12'h1E1
`define CPC_IDX_XFER        12'h232
`define CPC_IDX_STATUS      12'h233

// Byte addresses
`define CPC_ADDR_LOOP       14'h0040
`define CPC_ADDR_CAL        14'h0060
`define CPC_ADDR_PREDIV     14'h0780
`define CPC_ADDR_SRC        14'h0784
`define CPC_ADDR_XFER       14'h08C8
`define CPC_ADDR_STATUS     14'h08CC

// Field positions
`define CPC_PWR_MSB         1
`define CPC_PWR_LSB         0
`define CPC_POL_BIT         7
`define CPC_CAL_BIT         0
`define CPC_PREDIV_MSB      2
`define CPC_PREDIV_LSB      0
`define CPC_BYPASS_BIT      0
`define CPC_SRCSEL_BIT      1
`define CPC_XFER_BIT        0
`define CPC_STAT_BUSY_BIT   0
`define CPC_STAT_LOOP_BIT   1
`define CPC_STAT_OSC_BIT    2
`define CPC_STAT_PATH_BIT   3
`define CPC_STAT_DIV_MSB    6
`define CPC_STAT_DIV_LSB    4

// Reset values
`define CPC_RST_LOOP        8'h01
`define CPC_RST_CAL         8'h00
`define CPC_RST_PREDIV      8'h02
`define CPC_RST_SRC         8'h00

// Codes
`define CPC_XFER_GO         8'h01
`define CPC_PWR_NORMAL      2'h0
`define CPC_PWR_ASYNC_DOWN  2'h1
`define CPC_DIV_MIN         3'h2
`define CPC_DIV_MAX         3'h6
`define CPC_DIV_CODE_MAX    3'h4
`define CPC_DIV_NONE        3'h1
`define CPC_RESP_OKAY       2'h0
`define CPC_RESP_SLVERR     2'h2

`endif

// *** core/cpc_pkg.sv ***
`default_nettype none
package cpc_pkg;

	typedef enum logic [1:0] {
		CPC_CAL_IDLE = 2'h0,
		CPC_CAL_RUN  = 2'h1
	} cpc_cal_state_t;

	typedef struct packed {
		logic [7:0] loop;
		logic [7:0] cal;
		logic [7:0] prediv;
		logic [7:0] src;
	} cpc_cfg_t;

	typedef struct packed {
		logic        en;
		logic [13:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} cpc_wr_req_t;

	typedef struct packed {
		logic        en;
		logic [13:0] addr;
	} cpc_rd_req_t;

	typedef struct packed {
		logic [31:0] data;
		logic        err;
	} cpc_rd_rsp_t;

	typedef struct packed {
		logic [1:0] loop_power;
		logic       loop_enable;
		logic       loop_power_down;
		logic       detector_negative;
		logic       internal_osc_enable;
		logic       prescaler_from_external;
		logic       prediv_in_path;
		logic [2:0] divide;
		logic       cal_start;
	} cpc_path_out_t;

	typedef struct packed {
		cpc_cfg_t       stg;
		cpc_cfg_t       act;
		cpc_cal_state_t cal_st;
		logic           sync1;
		logic           sync2;
		logic           sync3;
		cpc_path_out_t  path;
	} cpc_core_st_t;

	typedef struct packed {
		logic        aw_held;
		logic [13:0] aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cpc_axil_st_t;

endpackage
`default_nettype wire

// *** core/cpc_top.sv ***
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module cpc_top (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	input  wire logic [13:0]   s_axil_awaddr,
	input  wire logic          s_axil_awvalid,
	output logic               s_axil_awready,
	input  wire logic [31:0]   s_axil_wdata,
	input  wire logic [3:0]    s_axil_wstrb,
	input  wire logic          s_axil_wvalid,
	output logic               s_axil_wready,
	output logic [1:0]         s_axil_bresp,
	output logic               s_axil_bvalid,
	input  wire logic          s_axil_bready,
	input  wire logic [13:0]   s_axil_araddr,
	input  wire logic          s_axil_arvalid,
	output logic               s_axil_arready,
	output logic [31:0]        s_axil_rdata,
	output logic [1:0]         s_axil_rresp,
	output logic               s_axil_rvalid,
	input  wire logic          s_axil_rready,
	input  wire logic          cal_done_async,
	output cpc_pkg::cpc_path_out_t path
);
	import cpc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Path decode

	function automatic cpc_path_out_t path_of(input cpc_cfg_t c, input logic start);
		cpc_path_out_t p;
		logic [2:0]    code;
		code = c.prediv[`CPC_PREDIV_MSB:`CPC_PREDIV_LSB];
		p.loop_power = c.loop[`CPC_PWR_MSB:`CPC_PWR_LSB];
		p.loop_enable = (p.loop_power == `CPC_PWR_NORMAL);
		p.loop_power_down = (p.loop_power == `CPC_PWR_ASYNC_DOWN);
		p.detector_negative = c.loop[`CPC_POL_BIT];
		p.internal_osc_enable = c.src[`CPC_SRCSEL_BIT];
		p.prescaler_from_external = p.loop_enable && !c.src[`CPC_SRCSEL_BIT];
		p.prediv_in_path = !c.src[`CPC_BYPASS_BIT];
		if (!p.prediv_in_path) begin
			p.divide = `CPC_DIV_NONE;
		end else if (code > `CPC_DIV_CODE_MAX) begin
			// Undefined codes clamp to the deepest ratio, the safe side for the dividers
			p.divide = `CPC_DIV_MAX;
		end else begin
			p.divide = code + `CPC_DIV_MIN;
		end
		p.cal_start = start;
		return p;
	endfunction

	localparam cpc_cfg_t CFG_RST = '{loop: `CPC_RST_LOOP, cal: `CPC_RST_CAL,
		prediv: `CPC_RST_PREDIV, src: `CPC_RST_SRC};
	localparam cpc_core_st_t ST_RST = '{stg: CFG_RST, act: CFG_RST, cal_st: CPC_CAL_IDLE,
		sync1: 1'b0, sync2: 1'b0, sync3: 1'b0, path: path_of(CFG_RST, 1'b0)};

	cpc_core_st_t s;
	cpc_core_st_t next_s;
	cpc_wr_req_t  wr;
	cpc_rd_req_t  rd;
	cpc_rd_rsp_t  rd_rsp;
	logic         wr_err;
	logic         xfer_go;
	logic [7:0]   status;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave

	cpc_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.awaddr  (s_axil_awaddr),
		.awvalid (s_axil_awvalid),
		.awready (s_axil_awready),
		.wdata   (s_axil_wdata),
		.wstrb   (s_axil_wstrb),
		.wvalid  (s_axil_wvalid),
		.wready  (s_axil_wready),
		.bresp   (s_axil_bresp),
		.bvalid  (s_axil_bvalid),
		.bready  (s_axil_bready),
		.araddr  (s_axil_araddr),
		.arvalid (s_axil_arvalid),
		.arready (s_axil_arready),
		.rdata   (s_axil_rdata),
		.rresp   (s_axil_rresp),
		.rvalid  (s_axil_rvalid),
		.rready  (s_axil_rready),
		.wr      (wr),
		.wr_err  (wr_err),
		.rd      (rd),
		.rd_rsp  (rd_rsp)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode and status

	always_comb begin
		unique case (wr.addr[13:2])
			`CPC_IDX_LOOP, `CPC_IDX_CAL, `CPC_IDX_PREDIV, `CPC_IDX_SRC,
			`CPC_IDX_XFER, `CPC_IDX_STATUS: wr_err = 1'b0;
			default: wr_err = 1'b1;
		endcase
	end

	// Only an exact 0x01 in the low byte commits; other values are ignored
	assign xfer_go = wr.en && wr.strb[0] && (wr.addr[13:2] == `CPC_IDX_XFER)
		&& (wr.data[7:0] == `CPC_XFER_GO);

	always_comb begin
		status = 8'h00;
		status[`CPC_STAT_BUSY_BIT] = (s.cal_st == CPC_CAL_RUN);
		status[`CPC_STAT_LOOP_BIT] = s.path.loop_enable;
		status[`CPC_STAT_OSC_BIT]  = s.path.internal_osc_enable;
		status[`CPC_STAT_PATH_BIT] = s.path.prediv_in_path;
		status[`CPC_STAT_DIV_MSB:`CPC_STAT_DIV_LSB] = s.path.divide;
	end

	// Config registers read back the staged copy, not the active one
	always_comb begin
		rd_rsp = '{data: 32'h0000_0000, err: 1'b0};
		unique case (rd.addr[13:2])
			`CPC_IDX_LOOP:   rd_rsp.data[7:0] = s.stg.loop;
			`CPC_IDX_CAL:    rd_rsp.data[7:0] = s.stg.cal;
			`CPC_IDX_PREDIV: rd_rsp.data[7:0] = s.stg.prediv;
			`CPC_IDX_SRC:    rd_rsp.data[7:0] = s.stg.src;
			`CPC_IDX_XFER:   rd_rsp.data[7:0] = 8'h00;
			`CPC_IDX_STATUS: rd_rsp.data[7:0] = status;
			default:         rd_rsp.err = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Staging, transfer and calibration

	always_comb begin
		next_s = s;
		next_s.sync1 = cal_done_async;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		if (wr.en && wr.strb[0]) begin
			unique case (wr.addr[13:2])
				`CPC_IDX_LOOP:   next_s.stg.loop = wr.data[7:0];
				`CPC_IDX_CAL:    next_s.stg.cal = wr.data[7:0];
				`CPC_IDX_PREDIV: next_s.stg.prediv = wr.data[7:0];
				`CPC_IDX_SRC:    next_s.stg.src = wr.data[7:0];
				default: ;
			endcase
		end
		if (xfer_go) begin
			next_s.act = s.stg;
		end
		if (s.cal_st == CPC_CAL_RUN && s.sync2 && !s.sync3) begin
			next_s.cal_st = CPC_CAL_IDLE;
		end
		// A fresh 0 to 1 on the active bit is what starts a run, so a host must
		// clear and transfer before every later run
		if (!s.act.cal[`CPC_CAL_BIT] && next_s.act.cal[`CPC_CAL_BIT]) begin
			next_s.cal_st = CPC_CAL_RUN;
		end
		next_s.path = path_of(next_s.act,
			!s.act.cal[`CPC_CAL_BIT] && next_s.act.cal[`CPC_CAL_BIT]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= ST_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign path = s.path;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_cal_armed;
		!s.act.cal[`CPC_CAL_BIT] ##1 s.act.cal[`CPC_CAL_BIT];
	endsequence

	sequence s_cal_begin;
		path.cal_start && (s.cal_st == CPC_CAL_RUN);
	endsequence

	chk_reset_defaults: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> (path.loop_power == `CPC_PWR_ASYNC_DOWN) && path.prediv_in_path
			&& (path.divide == 3'h4) && !path.internal_osc_enable && !path.loop_enable)
		else $error("path not at defaults after reset");

	chk_stage_hold: assert property (
		!(ce && xfer_go) |=> $stable(s.act) && $stable(path.divide))
		else $error("active set changed without transfer");

	chk_xfer_apply: assert property (
		ce && xfer_go |=> (s.act == $past(s.stg)))
		else $error("transfer did not copy staged values");

	chk_loop_power: assert property (
		(path.loop_enable == (s.act.loop[1:0] == 2'h0))
		&& (path.loop_power_down == (s.act.loop[1:0] == 2'h1)))
		else $error("loop power code decoded wrong");

	chk_divide_ratio: assert property (
		!s.act.src[0] && (s.act.prediv[2:0] <= 3'h4)
		|-> (path.divide == s.act.prediv[2:0] + 3'h2) && (path.divide >= 3'h2))
		else $error("pre-divider ratio wrong");

	chk_bypass_path: assert property (
		s.act.src[0] |-> !path.prediv_in_path && (path.divide == 3'h1))
		else $error("bypass not honoured");

	chk_source_osc: assert property (
		path.loop_enable && !s.act.src[1]
		|-> !path.internal_osc_enable && path.prescaler_from_external)
		else $error("internal oscillator on with external source");

	chk_polarity: assert property (
		path.detector_negative == s.act.loop[7])
		else $error("detector polarity wrong");

	chk_cal_begin: assert property (
		s_cal_armed |-> s_cal_begin)
		else $error("calibration did not start on armed bit");

	chk_cal_finish: assert property (
		ce && (s.cal_st == CPC_CAL_RUN) && s.sync2 && !s.sync3 && !xfer_go
		|=> (s.cal_st == CPC_CAL_IDLE) && !path.cal_start)
		else $error("calibration did not end on done");

	////////////////////////////////////////////////////////////////////////////////
	// Further checks

	chk_clamp_ratio: assert property (
		!s.act.src[0] && (s.act.prediv[2:0] > 3'h4) |-> (path.divide == 3'h6))
		else $error("undefined pre-divider code not clamped");

	chk_least_divide: assert property (
		path.prediv_in_path |-> (path.divide >= 3'h2) && (path.divide <= 3'h6))
		else $error("pre-divider ratio out of range");

	chk_start_pulse: assert property (
		ce && path.cal_start |=> !path.cal_start)
		else $error("calibration start wider than one cycle");

	chk_start_busy: assert property (
		path.cal_start |-> (s.cal_st == CPC_CAL_RUN))
		else $error("calibration start without busy state");

	chk_stage_loop: assert property (
		ce && wr.en && wr.strb[0] && (wr.addr[13:2] == `CPC_IDX_LOOP)
		|=> (s.stg.loop == $past(wr.data[7:0])))
		else $error("loop register write not staged");

	chk_stage_src: assert property (
		ce && wr.en && wr.strb[0] && (wr.addr[13:2] == `CPC_IDX_SRC)
		|=> (s.stg.src == $past(wr.data[7:0])))
		else $error("source register write not staged");

	chk_xfer_ignored: assert property (
		ce && wr.en && (wr.addr[13:2] == `CPC_IDX_XFER) && (wr.data[7:0] != `CPC_XFER_GO)
		|=> $stable(s.act))
		else $error("active set changed on a non-commit value");

	chk_osc_follows: assert property (
		path.internal_osc_enable == s.act.src[1])
		else $error("oscillator enable does not follow source bit");

	chk_prescaler_src: assert property (
		path.prescaler_from_external == (path.loop_enable && !s.act.src[1]))
		else $error("prescaler source decoded wrong");

	chk_freeze_state: assert property (
		!ce |=> $stable(s.act) && $stable(s.stg) && $stable(s.cal_st))
		else $error("state moved while clock enable low");

	chk_reset_state: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> (s.cal_st == CPC_CAL_IDLE) && (s.act == CFG_RST)
			&& (s.stg == CFG_RST))
		else $error("state not at defaults after reset");

endmodule
`default_nettype wire

// *** verif/cpc_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cpc_osc_model #(
	parameter int CAL_CYCLES = 20
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic cal_start,
	output logic      cal_done_async
);
	int cnt;

	// Done lands 3 ns after an edge: a real oscillator is not tied to aclk
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
		end else if (cal_start === 1'b1) begin
			cnt <= CAL_CYCLES + 4;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		cal_done_async <= #3 (cnt >= 1 && cnt <= 4);
	end
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module testbench;
	import cpc_pkg::*;
	logic          aclk;
	logic          aresetn;
	logic          ce;
	logic [13:0]   awaddr;
	logic          awvalid;
	logic          awready;
	logic [31:0]   wdata;
	logic [3:0]    wstrb;
	logic          wvalid;
	logic          wready;
	logic [1:0]    bresp;
	logic          bvalid;
	logic          bready;
	logic [13:0]   araddr;
	logic          arvalid;
	logic          arready;
	logic [31:0]   rdata;
	logic [1:0]    rresp;
	logic          rvalid;
	logic          rready;
	logic          cal_done;
	cpc_path_out_t path;
	int            mismatches;
	int            checks;
	int            starts;

	cpc_top u_dut (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.ce             (ce),
		.s_axil_awaddr  (awaddr),
		.s_axil_awvalid (awvalid),
		.s_axil_awready (awready),
		.s_axil_wdata   (wdata),
		.s_axil_wstrb   (wstrb),
		.s_axil_wvalid  (wvalid),
		.s_axil_wready  (wready),
		.s_axil_bresp   (bresp),
		.s_axil_bvalid  (bvalid),
		.s_axil_bready  (bready),
		.s_axil_araddr  (araddr),
		.s_axil_arvalid (arvalid),
		.s_axil_arready (arready),
		.s_axil_rdata   (rdata),
		.s_axil_rresp   (rresp),
		.s_axil_rvalid  (rvalid),
		.s_axil_rready  (rready),
		.cal_done_async (cal_done),
		.path           (path)
	);

	cpc_osc_model u_osc (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.cal_start      (path.cal_start),
		.cal_done_async (cal_done)
	);

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// A stuck pulse would be counted every cycle, so the count also checks its width
	always @(posedge aclk) begin
		if (path.cal_start === 1'b1) begin
			starts++;
		end
	end

	////////////////////////////////////////////////////////////
	task automatic conclude();
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [13:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] er = 2'h0);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk(rdata & m, e & m);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// Extra edge so the pulse counter has seen the transfer cycle
	task automatic xfer();
		wr(`CPC_ADDR_XFER, 8'h01, 2'h0);
		@(posedge aclk);
	endtask

	task automatic chk_path(input logic [7:0] lp, input logic [7:0] pd, input logic [7:0] sr);
		cpc_path_out_t e;
		e = '0;
		#1;
		e.loop_power = lp[1:0];
		e.loop_enable = (lp[1:0] == 2'h0);
		e.loop_power_down = (lp[1:0] == 2'h1);
		e.detector_negative = lp[7];
		e.internal_osc_enable = sr[1];
		e.prescaler_from_external = e.loop_enable && !sr[1];
		e.prediv_in_path = !sr[0];
		e.divide = sr[0] ? 3'h1 : (pd[2:0] > 3'h4) ? 3'h6 : pd[2:0] + 3'h2;
		chk({20'h0, path}, {20'h0, e});
	endtask

	////////////////////////////////////////////////////////////
	task automatic t_defaults();
		chk_path(8'h01, 8'h02, 8'h00);
		rd(`CPC_ADDR_LOOP, 32'h01);
		rd(`CPC_ADDR_CAL, 32'h00);
		rd(`CPC_ADDR_PREDIV, 32'h02);
		rd(`CPC_ADDR_SRC, 32'h00);
	endtask

	task automatic t_staging();
		wr(`CPC_ADDR_LOOP, 8'h80, 2'h0);
		rd(`CPC_ADDR_LOOP, 32'h80);
		chk_path(8'h01, 8'h02, 8'h00);
		wr(`CPC_ADDR_XFER, 8'h03, 2'h0);
		chk_path(8'h01, 8'h02, 8'h00);
		xfer();
		chk_path(8'h80, 8'h02, 8'h00);
		rd(`CPC_ADDR_XFER, 32'h0);
		wr(`CPC_ADDR_LOOP, 8'h01, 2'h0);
		xfer();
		chk_path(8'h01, 8'h02, 8'h00);
	endtask

	task automatic t_paths();
		wr(`CPC_ADDR_LOOP, 8'h00, 2'h0);
		for (int i = 0; i < 5; i++) begin
			wr(`CPC_ADDR_PREDIV, 8'(i), 2'h0);
			xfer();
			chk_path(8'h00, 8'(i), 8'h00);
		end
		for (int j = 3; j >= 0; j--) begin
			wr(`CPC_ADDR_SRC, 8'(j), 2'h0);
			xfer();
			chk_path(8'h00, 8'h04, 8'(j));
		end
		// Undefined ratio code must clamp, never wrap below 2
		wr(`CPC_ADDR_PREDIV, 8'h07, 2'h0);
		xfer();
		chk_path(8'h00, 8'h07, 8'h00);
	endtask

	task automatic t_cal();
		int s0;
		s0 = starts;
		wr(`CPC_ADDR_CAL, 8'h01, 2'h0);
		@(posedge aclk);
		chk(starts, s0);
		xfer();
		chk(starts, s0 + 1);
		rd(`CPC_ADDR_STATUS, 32'h01, 32'h01);
		repeat (40) @(posedge aclk);
		rd(`CPC_ADDR_STATUS, 32'h00, 32'h01);
		xfer();
		chk(starts, s0 + 1);
		wr(`CPC_ADDR_CAL, 8'h00, 2'h0);
		xfer();
		wr(`CPC_ADDR_CAL, 8'h01, 2'h0);
		xfer();
		chk(starts, s0 + 2);
		repeat (40) @(posedge aclk);
	endtask

	task automatic t_errors();
		wr(14'h0100, 8'h55, `CPC_RESP_SLVERR);
		rd(14'h0100, 32'h0, 32'hFFFFFFFF, `CPC_RESP_SLVERR);
		wr(`CPC_ADDR_STATUS, 8'hFF, 2'h0);
		rd(`CPC_ADDR_STATUS, 32'h00, 32'h01);
		// Low byte lane off: the write is answered but must change nothing
		wstrb <= 4'hE;
		wr(`CPC_ADDR_LOOP, 8'h55, 2'h0);
		wstrb <= 4'hF;
		rd(`CPC_ADDR_LOOP, 32'h00);
	endtask

	// Commit offered while frozen; it may only land once the enable returns
	task automatic t_freeze();
		wr(`CPC_ADDR_LOOP, 8'h80, 2'h0);
		ce <= 1'b0;
		fork
			xfer();
			begin
				repeat (3) @(posedge aclk);
				chk({29'h0, awready, wready, arready}, 32'h0);
				ce <= 1'b1;
				chk_path(8'h00, 8'h07, 8'h00);
			end
		join
		chk_path(8'h80, 8'h07, 8'h00);
	endtask

	task automatic t_reset_again();
		wr(`CPC_ADDR_LOOP, 8'h80, 2'h0);
		wr(`CPC_ADDR_SRC, 8'h03, 2'h0);
		xfer();
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_defaults();
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0;
		checks = 0;
		starts = 0;
		aresetn = 1'b0;
		ce = 1'b1;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = 4'hF;
		wvalid = 1'b0;
		// Answer readies stay high, so back-to-back calls never toggle them in one step
		bready = 1'b1;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_defaults();
		t_staging();
		t_paths();
		t_cal();
		t_errors();
		t_freeze();
		t_reset_again();
		conclude();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		conclude();
	end
endmodule

`default_nettype wire
